/* File: isce_consts.svh */
// Constants for the switch-config expander: register map, reset values,
// two-wire address and port bit assignments.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ISCE_CONSTS_SVH
`define ISCE_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define ISCE_REG_DIR_A      8'h00
`define ISCE_REG_DIR_B      8'h01
`define ISCE_REG_OUT_A      8'h12
`define ISCE_REG_OUT_B      8'h13
`define ISCE_DIR_RESET      8'hff
`define ISCE_OUT_RESET      8'h00
`define ISCE_UNMAPPED_READ  8'h00

// ****************************************************************
// Two-wire bus
// ****************************************************************
`define ISCE_DEV_ADDR       7'h22
`define ISCE_BIT_COUNT_LAST 4'h7
`define ISCE_BIT_COUNT_ACK  4'h8

// ****************************************************************
// Port A bit assignments
// ****************************************************************
`define ISCE_A_MEM_CS       0
`define ISCE_A_BUTTONS      1
`define ISCE_A_CARD_ROUTE   2
`define ISCE_A_USB_BRIDGE   3
`define ISCE_A_CAN          4
`define ISCE_A_AUDIO_RESET  5
`define ISCE_A_DAC_PATH     6
`define ISCE_A_ADC_PATH     7

`endif

/* File: isce_pkg.sv */
// Types for the switch-config expander.
// Assumes the constants header is on the include path.
`include "isce_consts.svh"

package isce_pkg;

  // Two-wire slave states
  typedef enum logic [2:0]
  {
    ISCE_IDLE    = 3'b000,
    ISCE_ADDR    = 3'b001,
    ISCE_ADDR_AK = 3'b010,
    ISCE_RX      = 3'b011,
    ISCE_RX_AK   = 3'b100,
    ISCE_TX      = 3'b101,
    ISCE_TX_AK   = 3'b110,
    ISCE_IGNORE  = 3'b111
  } isce_state_e;

  typedef logic [7:0] isce_byte_t;

endpackage : isce_pkg

/* File: isce_expander.sv */
// Two-wire controlled sixteen-bit output expander for board switch lines.
// Assumes scl and sda arrive from pins, asynchronous to clk_sys, and that
// clk_sys is far faster than the two-wire bit rate.
//
// Functional notes
// RULE1: Eight-bit data registers, one bit per line
// RULE2: Data registers at 0x12, 0x13; reset 0x00
// RULE3: Direction registers at 0x00 and 0x01
// RULE4: All pins inputs after reset
// RULE5: Direction zero drives data; one stays input
// RULE6: Host sets output before trusting data bit
// RULE7: Answer at seven-bit address 0100010
// RULE8: FET enable low connects, high disconnects
// RULE9: Select low numbered group, high lettered
// RULE10: A0 memory select, A1 pushbuttons
// RULE11: A2 card, A3 USB, A4 CAN, A6/A7 audio
// RULE12: A5 drives audio converters reset directly
// RULE13: Write: register byte, data byte, apply at ack
`timescale 1ns/100ps
`include "isce_consts.svh"

module isce_expander
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Two-wire bus pins, open drain on sda
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // Port A pins
  output logic [7:0]      port_a_o,
  output logic [7:0]      port_a_oe,
  // Port B pins
  output logic [7:0]      port_b_o,
  output logic [7:0]      port_b_oe,
  // Named port A lines, port A data bit whatever the direction
  output logic            mem_cs_switch_en,
  output logic            buttons_switch_en,
  output logic            card_socket_route,
  output logic            usb_bridge_enable,
  output logic            can_enable,
  output logic            audio_converters_reset,
  output logic            dac_path_enable,
  output logic            adc_path_enable
);

  // ****************************************************************
  // Pin synchronisers and bus event detection
  // ****************************************************************
  logic [1:0]           scl_sync_q;
  logic [1:0]           sda_sync_q;
  logic                 scl_prev_q;
  logic                 sda_prev_q;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_seen;
  logic                 stop_seen;

  // Two stages each; only the second stage feeds logic
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Start and stop are sda edges while scl is high
  assign scl_rise   = scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall   = ~scl_sync_q[1] & scl_prev_q;
  assign start_seen = scl_sync_q[1] & scl_prev_q & sda_prev_q
                      & ~sda_sync_q[1];
  assign stop_seen  = scl_sync_q[1] & scl_prev_q & ~sda_prev_q
                      & sda_sync_q[1];

  // ****************************************************************
  // Two-wire slave
  // ****************************************************************
  isce_pkg::isce_state_e state_q;
  isce_pkg::isce_byte_t  shift_q;
  isce_pkg::isce_byte_t  reg_ptr_q;
  isce_pkg::isce_byte_t  tx_q;
  logic [3:0]            bit_cnt_q;
  logic                  ptr_loaded_q;
  logic                  sda_drive_q;
  logic                  wr_strobe;
  isce_pkg::isce_byte_t  rd_data;

  isce_pkg::isce_byte_t  dir_a_q;
  isce_pkg::isce_byte_t  dir_b_q;
  isce_pkg::isce_byte_t  out_a_q;
  isce_pkg::isce_byte_t  out_b_q;

  // Register read mux, unmapped addresses read zero
  function automatic isce_pkg::isce_byte_t read_reg
  (
    input isce_pkg::isce_byte_t addr
  );
    case (addr)
      `ISCE_REG_DIR_A: read_reg = dir_a_q;   // see RULE3
      `ISCE_REG_DIR_B: read_reg = dir_b_q;   // see RULE3
      `ISCE_REG_OUT_A: read_reg = out_a_q;   // see RULE2
      `ISCE_REG_OUT_B: read_reg = out_b_q;   // see RULE2
      default:         read_reg = `ISCE_UNMAPPED_READ;
    endcase
  endfunction : read_reg

  assign rd_data = read_reg(reg_ptr_q);

  // Data byte is applied on the scl rise that samples its ack
  assign wr_strobe = (state_q == isce_pkg::ISCE_RX_AK) && scl_rise
                     && ptr_loaded_q;            // see RULE13

  // Bit sequencer; a start always restarts address reception
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q      <= isce_pkg::ISCE_IDLE;
      shift_q      <= 8'h00;
      bit_cnt_q    <= 4'h0;
      ptr_loaded_q <= 1'b0;
      reg_ptr_q    <= 8'h00;
      tx_q         <= 8'h00;
    end
    else if (start_seen)
    begin
      state_q   <= isce_pkg::ISCE_ADDR;
      bit_cnt_q <= 4'h0;
    end
    else if (stop_seen)
    begin
      state_q <= isce_pkg::ISCE_IDLE;
    end
    else
    begin
      case (state_q)
        isce_pkg::ISCE_ADDR, isce_pkg::ISCE_RX:
        begin
          if (scl_rise)
          begin
            shift_q   <= {shift_q[6:0], sda_sync_q[1]};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          if (scl_fall && bit_cnt_q == `ISCE_BIT_COUNT_ACK)
          begin
            bit_cnt_q <= 4'h0;
            if (state_q == isce_pkg::ISCE_RX)
              state_q <= isce_pkg::ISCE_RX_AK;
            else if (shift_q[7:1] == `ISCE_DEV_ADDR) // see RULE7
              state_q <= isce_pkg::ISCE_ADDR_AK;
            else
              state_q <= isce_pkg::ISCE_IGNORE;
          end
        end
        isce_pkg::ISCE_ADDR_AK:
        begin
          if (scl_fall)
          begin
            if (shift_q[0])
            begin
              state_q <= isce_pkg::ISCE_TX;
              tx_q    <= rd_data;
            end
            else
            begin
              state_q      <= isce_pkg::ISCE_RX;
              ptr_loaded_q <= 1'b0;
            end
          end
        end
        isce_pkg::ISCE_RX_AK:
        begin
          // First byte sets the pointer, later ones write and advance
          if (scl_rise)
          begin
            if (!ptr_loaded_q)
            begin
              reg_ptr_q    <= shift_q;
              ptr_loaded_q <= 1'b1;
            end
            else
              reg_ptr_q <= reg_ptr_q + 8'h01;
          end
          if (scl_fall)
            state_q <= isce_pkg::ISCE_RX;
        end
        isce_pkg::ISCE_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_q == `ISCE_BIT_COUNT_LAST)
            begin
              bit_cnt_q <= 4'h0;
              state_q   <= isce_pkg::ISCE_TX_AK;
            end
            else
            begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
              tx_q      <= {tx_q[6:0], 1'b0};
            end
          end
        end
        isce_pkg::ISCE_TX_AK:
        begin
          // A host nack ends the read; an ack fetches the next register
          if (scl_rise)
          begin
            if (sda_sync_q[1])
              state_q <= isce_pkg::ISCE_IGNORE;
            else
              reg_ptr_q <= reg_ptr_q + 8'h01;
          end
          if (scl_fall && state_q == isce_pkg::ISCE_TX_AK)
          begin
            state_q <= isce_pkg::ISCE_TX;
            tx_q    <= rd_data;
          end
        end
        isce_pkg::ISCE_IGNORE, isce_pkg::ISCE_IDLE:
          bit_cnt_q <= 4'h0;
        default:
          state_q <= isce_pkg::ISCE_IDLE;
      endcase
    end
  end

  // Sda is changed only while scl is low, so no false start/stop
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sda_drive_q <= 1'b0;
    else if (start_seen || stop_seen)
      sda_drive_q <= 1'b0;
    else if (scl_fall || state_q == isce_pkg::ISCE_IDLE)
    begin
      case (state_q)
        isce_pkg::ISCE_ADDR:
          sda_drive_q <= (bit_cnt_q == `ISCE_BIT_COUNT_ACK)
                         && (shift_q[7:1] == `ISCE_DEV_ADDR);
        isce_pkg::ISCE_RX:
          sda_drive_q <= (bit_cnt_q == `ISCE_BIT_COUNT_ACK);
        isce_pkg::ISCE_ADDR_AK:
          sda_drive_q <= shift_q[0] && !rd_data[7];
        isce_pkg::ISCE_TX:
          sda_drive_q <= (bit_cnt_q != `ISCE_BIT_COUNT_LAST)
                         && !tx_q[6];
        isce_pkg::ISCE_TX_AK:
          sda_drive_q <= !rd_data[7];
        default:
          sda_drive_q <= 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Direction resets to all ones so no switch line is driven
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dir_a_q <= `ISCE_DIR_RESET;                // see RULE4
      dir_b_q <= `ISCE_DIR_RESET;                // see RULE4
      out_a_q <= `ISCE_OUT_RESET;                // see RULE2
      out_b_q <= `ISCE_OUT_RESET;                // see RULE2
    end
    else if (wr_strobe)
    begin
      case (reg_ptr_q)
        `ISCE_REG_DIR_A: dir_a_q <= shift_q;     // see RULE3
        `ISCE_REG_DIR_B: dir_b_q <= shift_q;     // see RULE3
        `ISCE_REG_OUT_A: out_a_q <= shift_q;     // see RULE1
        `ISCE_REG_OUT_B: out_b_q <= shift_q;     // see RULE1
        default:         ;
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Registered so every output comes straight from a flip-flop; pins
  // follow a write one clock later. Pull resistors, not this block, set
  // a line while its direction bit is one. Named lines carry the port A
  // data bit whatever the direction; the audio reset has no switch.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      port_a_o  <= `ISCE_OUT_RESET;
      port_b_o  <= `ISCE_OUT_RESET;
      port_a_oe <= 8'h00;
      port_b_oe <= 8'h00;
      sda_o     <= 1'b0;
      sda_oe    <= 1'b0;
      mem_cs_switch_en       <= 1'b0;
      buttons_switch_en      <= 1'b0;
      card_socket_route      <= 1'b0;
      usb_bridge_enable      <= 1'b0;
      can_enable             <= 1'b0;
      audio_converters_reset <= 1'b0;
      dac_path_enable        <= 1'b0;
      adc_path_enable        <= 1'b0;
    end
    else
    begin
      port_a_o  <= out_a_q;                      // see RULE1
      port_b_o  <= out_b_q;                      // see RULE1
      port_a_oe <= ~dir_a_q;                     // see RULE5
      port_b_oe <= ~dir_b_q;                     // see RULE5
      sda_o     <= 1'b0;
      sda_oe    <= sda_drive_q;
      mem_cs_switch_en       <= out_a_q[`ISCE_A_MEM_CS];   // see RULE10
      buttons_switch_en      <= out_a_q[`ISCE_A_BUTTONS];  // see RULE8
      card_socket_route      <= out_a_q[`ISCE_A_CARD_ROUTE]; // see RULE9
      usb_bridge_enable      <= out_a_q[`ISCE_A_USB_BRIDGE]; // see RULE11
      can_enable             <= out_a_q[`ISCE_A_CAN];      // see RULE11
      audio_converters_reset <= out_a_q[`ISCE_A_AUDIO_RESET]; // see RULE12
      dac_path_enable        <= out_a_q[`ISCE_A_DAC_PATH]; // see RULE11
      adc_path_enable        <= out_a_q[`ISCE_A_ADC_PATH]; // see RULE11
    end
  end

endmodule : isce_expander

/* File: isce_expander_checker.sv */
// Checker for the switch-config expander, bound onto its ports.
// Assumes one clock domain, clk_sys, with rst synchronous active high.
`timescale 1ns/100ps

module isce_expander_checker
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Two-wire pins
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  // Port pins
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_o,
  input wire logic [7:0] port_b_oe,
  // Named port A lines
  input wire logic       mem_cs_switch_en,
  input wire logic       buttons_switch_en,
  input wire logic       card_socket_route,
  input wire logic       usb_bridge_enable,
  input wire logic       can_enable,
  input wire logic       audio_converters_reset,
  input wire logic       dac_path_enable,
  input wire logic       adc_path_enable
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  wire [7:0] named;

  // Named lines gathered in port A bit order
  assign named = {adc_path_enable, dac_path_enable,
                  audio_converters_reset, can_enable, usb_bridge_enable,
                  card_socket_route, buttons_switch_en, mem_cs_switch_en};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_rst_oe;
    $fell(rst) |-> port_a_oe == 8'h00 && port_b_oe == 8'h00;
  endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("pins driven after reset");

  property p_rst_out;
    $fell(rst) |-> port_a_o == 8'h00 && port_b_o == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("data not zero after reset");

  // Lines and port A data share one register stage, so never differ
  property p_named;
    named == port_a_o;
  endproperty
  a_named: assert property (p_named)
    else $error("named lines differ from port a data");

  // Pins move only while the data byte is being acknowledged
  property p_port_ack;
    !$stable({port_a_o, port_a_oe, port_b_o, port_b_oe})
      |-> sda_oe || $past(rst);
  endproperty
  a_port_ack: assert property (p_port_ack)
    else $error("port changed outside an acknowledge");

  // A change of sda while scl is high would look like start or stop
  property p_sda_scl_low;
    !$stable(sda_oe) |-> !scl_i && !$past(scl_i);
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("sda moved while scl high");

  property p_open_drain;
    sda_oe |-> sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("sda driven high");

  property p_one_reg;
    $onehot0({!$stable(port_a_o), !$stable(port_a_oe),
              !$stable(port_b_o), !$stable(port_b_oe)});
  endproperty
  a_one_reg: assert property (p_one_reg)
    else $error("two registers changed together");

  property p_dir_keeps_data;
    !$stable(port_a_oe) |=> $stable(named) [*2];
  endproperty
  a_dir_keeps_data: assert property (p_dir_keeps_data)
    else $error("direction write altered line values");

endmodule : isce_expander_checker

bind isce_expander isce_expander_checker u_isce_expander_checker
(
  .clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .port_a_o(port_a_o),
  .port_a_oe(port_a_oe), .port_b_o(port_b_o), .port_b_oe(port_b_oe),
  .mem_cs_switch_en(mem_cs_switch_en),
  .buttons_switch_en(buttons_switch_en),
  .card_socket_route(card_socket_route),
  .usb_bridge_enable(usb_bridge_enable), .can_enable(can_enable),
  .audio_converters_reset(audio_converters_reset),
  .dac_path_enable(dac_path_enable), .adc_path_enable(adc_path_enable)
);

/* File: isce_host_model.sv */
// Two-wire host model: start, stop, register writes and reads.
// Assumes pull-ups on both lines; moves only on clk_sys falling edges.
`timescale 1ns/100ps

module isce_host_model
(
  // Clock
  input  wire logic clk_sys,
  // Bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  localparam int HALF = 12; // Above the 8 clock minimum per phase

  // Idle bus: both lines released
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : hw

  // Data set four clocks into scl low, sampled at the end of scl high
  task automatic bit_io(input logic b, output logic r);
    hw(4);
    sda_pull = ~b;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    r = sda;
    scl = 1'b0;
  endtask : bit_io

  task automatic byte_io(input logic [7:0] tx, input logic ak_in,
                         output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ak_in, r);
    ack = ~r;
  endtask : byte_io

  // Also serves as repeated start
  task automatic start;
    hw(4);
    sda_pull = 1'b0;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    sda_pull = 1'b1;
    hw(HALF);
    scl = 1'b0;
  endtask : start

  task automatic stop;
    hw(4);
    sda_pull = 1'b1;
    hw(HALF);
    scl = 1'b1;
    hw(HALF);
    sda_pull = 1'b0;
    hw(HALF);
  endtask : stop

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra,
                           input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    byte_io(ra, 1'b1, rx, a1);
    byte_io(d, 1'b1, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ra, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, a3;
    start();
    byte_io({7'h22, 1'b0}, 1'b1, rx, a0);
    byte_io(ra, 1'b1, rx, a1);
    start();
    byte_io({7'h22, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hff, 1'b1, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask : read_reg

endmodule : isce_host_model

/* File: isce_expander_tb_top.sv */
// Testbench for the switch-config expander via the two-wire host model.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps

module isce_expander_tb_top;
  logic       clk_sys, rst, scl, sda, host_pull, sda_o, sda_oe, ok;
  logic [7:0] pa_o, pa_oe, pb_o, pb_oe, rd;
  wire  [7:0] named;
  int         errors, n_compared;

  // Open-drain sda with pull-up
  assign sda = !(host_pull || (sda_oe && !sda_o));

  isce_host_model u_isce_host_model
  (
    .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_pull(host_pull)
  );

  isce_expander u_isce_expander
  (
    .clk_sys(clk_sys), .rst(rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .port_a_o(pa_o), .port_a_oe(pa_oe),
    .port_b_o(pb_o), .port_b_oe(pb_oe), .mem_cs_switch_en(named[0]),
    .buttons_switch_en(named[1]), .card_socket_route(named[2]),
    .usb_bridge_enable(named[3]), .can_enable(named[4]),
    .audio_converters_reset(named[5]), .dac_path_enable(named[6]),
    .adc_path_enable(named[7])
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    u_isce_host_model.write_reg(7'h22, ra, d, ok);
    chk_bit(ok, 1'b1);
  endtask : wr

  task automatic rd_chk(input logic [7:0] ra, input logic [7:0] exp);
    u_isce_host_model.read_reg(ra, rd, ok);
    chk_bit(ok, 1'b1);
    chk_byte(rd, exp);
  endtask : rd_chk

  task automatic wrap_up;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Clock at 125 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Watchdog well beyond the roughly 20k clocks of traffic
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    errors     = 0;
    n_compared = 0;
    rst        = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk_byte(pa_oe, 8'h00);
    chk_byte(pb_oe, 8'h00);
    chk_byte(pa_o, 8'h00);
    chk_byte(pb_o, 8'h00);
    rd_chk(8'h12, 8'h00);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h00, 8'hff);
    rd_chk(8'h01, 8'hff);
    rd_chk(8'h05, 8'h00);
    // Data first: value lands but pins stay inputs
    wr(8'h12, 8'h5a);
    chk_byte(pa_o, 8'h5a);
    chk_byte(pa_oe, 8'h00);
    chk_byte(named, 8'h5a);
    wr(8'h00, 8'h00);
    chk_byte(pa_oe, 8'hff);
    // Walk a one across the named lines
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h12, 8'h01 << i);
      chk_byte(named, 8'h01 << i);
    end
    wr(8'h13, 8'h3c);
    wr(8'h01, 8'hf0);
    chk_byte(pb_o, 8'h3c);
    chk_byte(pb_oe, 8'h0f);
    rd_chk(8'h01, 8'hf0);
    rd_chk(8'h13, 8'h3c);
    // Another device address must be ignored
    u_isce_host_model.write_reg(7'h23, 8'h12, 8'hff, ok);
    chk_bit(ok, 1'b0);
    chk_byte(pa_o, 8'h80);
    wrap_up();
  end

endmodule : isce_expander_tb_top
